// File: verilog/remote_phy_register_access.sv
// Remote PHY register access framer with AXI4-Lite register slave
`timescale 1ns/100ps
module remote_phy_register_access
    import rpra_pkg::*;
#(
    parameter int unsigned ADDR_W = 8
)
(
    // Clock and reset
    input  wire logic              clock,
    input  wire logic              rst,
    // AXI4-Lite write channels
    input  wire logic [ADDR_W-1:0] awaddr,
    input  wire logic              awvalid,
    output logic                   awready,
    input  wire logic [31:0]       wdata,
    input  wire logic [3:0]        wstrb,
    input  wire logic              wvalid,
    output logic                   wready,
    output logic [1:0]             bresp,
    output logic                   bvalid,
    input  wire logic              bready,
    // AXI4-Lite read channels
    input  wire logic [ADDR_W-1:0] araddr,
    input  wire logic              arvalid,
    output logic                   arready,
    output logic [31:0]            rdata,
    output logic [1:0]             rresp,
    output logic                   rvalid,
    input  wire logic              rready,
    // Transmit quadlets toward the PHY
    output logic                   phy_tx_valid,
    output logic [31:0]            phy_tx_data,
    output logic                   phy_tx_last,
    input  wire logic              phy_tx_ready,
    // Receive quadlets from the PHY
    input  wire logic              phy_rx_valid,
    input  wire logic [31:0]       phy_rx_data,
    input  wire logic              phy_rx_last,
    input  wire rx_meta_t          phy_rx_meta
);

    // Bus slave state
    logic              aw_held_ff, w_held_ff, awready_ff, wready_ff, bvalid_ff;
    logic              arready_ff, rvalid_ff;
    logic [7:0]        aw_addr_ff;
    logic [31:0]       w_data_ff, rdata_ff;
    logic [3:0]        w_strb_ff;
    logic [1:0]        bresp_ff, rresp_ff;
    // Request and transmit state
    logic [31:0]       req_ff, buf0_ff, buf1_ff, tx_data_ff;
    logic              tx_pend_ff, tx_valid_ff, tx_last_ff, reject_ff;
    logic [3:0]        tgt_ff;
    tx_state_t         state_ff, nxt_state;
    // Receive state
    logic [13:0]       rx_cnt_ff, rx_len_ff;
    logic [31:0]       rx_q0_ff, rx_q1_ff, reply0_ff, reply1_ff;
    logic              rx_eval_ff, reply_ff, rxerr_ff;
    rx_meta_t          meta_ff;
    token_t            token_ff, nxt_token;

    // Write channel decode
    logic        aw_take, w_take, wr_fire, nxt_aw_held, nxt_w_held, wr_hit;
    logic        wr_ctrl, wr_req, wr_acc, wr_last, tx_idle, send_cmd;
    logic [31:0] wr_merged;
    access_q_t   built_q;

    // Byte-lane merge of a write into an old word
    function automatic logic [31:0] merge_strb(input logic [31:0] old_w, input logic [31:0] new_w,
                                               input logic [3:0] strb);
        for (int i = 0; i < 4; i++)
        begin
            merge_strb[8*i +: 8] = strb[i] ? new_w[8*i +: 8] : old_w[8*i +: 8];
        end
    endfunction

    // Address decode, shared by both channels
    function automatic logic is_mapped(input logic [7:0] a);
        is_mapped = (a[1:0] == 2'h0) && (a <= OFF_REPLY1);
    endfunction

    assign aw_take     = awvalid && awready_ff;
    assign w_take      = wvalid && wready_ff;
    assign wr_fire     = aw_held_ff && w_held_ff && !bvalid_ff;
    assign nxt_aw_held = wr_fire ? 1'b0 : (aw_take ? 1'b1 : aw_held_ff);
    assign nxt_w_held  = wr_fire ? 1'b0 : (w_take ? 1'b1 : w_held_ff);
    assign wr_hit      = is_mapped(aw_addr_ff);
    assign wr_merged   = merge_strb(32'h0000_0000, w_data_ff, w_strb_ff);
    assign wr_ctrl     = wr_fire && (aw_addr_ff == OFF_CTRL);
    assign wr_req      = wr_fire && (aw_addr_ff == OFF_REQ);
    assign wr_acc      = wr_fire && (aw_addr_ff == OFF_BUF_ACC) && tx_idle;
    assign wr_last     = wr_fire && (aw_addr_ff == OFF_BUF_LAST) && tx_idle;
    assign tx_idle     = (state_ff == TX_IDLE) && !tx_pend_ff;
    assign send_cmd    = wr_ctrl && wr_merged[CTRL_SEND_BIT] && tx_idle;

    // Write address and data capture, either order
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            aw_held_ff <= 1'b0;
            w_held_ff  <= 1'b0;
            awready_ff <= 1'b0;
            wready_ff  <= 1'b0;
            aw_addr_ff <= 8'h00;
            w_data_ff  <= 32'h0000_0000;
            w_strb_ff  <= 4'h0;
        end
        else
        begin
            aw_held_ff <= nxt_aw_held;
            w_held_ff  <= nxt_w_held;
            awready_ff <= !nxt_aw_held;
            wready_ff  <= !nxt_w_held;
            if (aw_take)
                aw_addr_ff <= 8'(awaddr);
            if (w_take)
            begin
                w_data_ff <= wdata;
                w_strb_ff <= wstrb;
            end
        end
    end

    // Write response, unmapped offsets answer SLVERR
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            bvalid_ff <= 1'b0;
            bresp_ff  <= RESP_OKAY;
        end
        else if (wr_fire)
        begin
            bvalid_ff <= 1'b1;
            bresp_ff  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
        end
        else if (bready)
            bvalid_ff <= 1'b0;
    end

    // Read decode of the register map
    logic        ar_take, nxt_rvalid;
    logic [7:0]  rd_addr;
    logic [31:0] rd_word, status_word;

    assign ar_take     = arvalid && arready_ff;
    assign nxt_rvalid  = ar_take ? 1'b1 : (rready ? 1'b0 : rvalid_ff);
    assign rd_addr     = 8'(araddr);
    assign status_word = {20'h00000, tgt_ff, 4'h0, reject_ff, rxerr_ff, reply_ff, !tx_idle ||
                          (state_ff != TX_IDLE)};
    assign rd_word     = (rd_addr == OFF_REQ)      ? req_ff      :
                         (rd_addr == OFF_BUF_ACC)  ? buf0_ff     :
                         (rd_addr == OFF_BUF_LAST) ? buf1_ff     :
                         (rd_addr == OFF_STATUS)   ? status_word :
                         (rd_addr == OFF_TOKEN)    ? token_ff    :
                         (rd_addr == OFF_REPLY0)   ? reply0_ff   :
                         (rd_addr == OFF_REPLY1)   ? reply1_ff   : 32'h0000_0000;

    // Read channel, one read under way at a time
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            arready_ff <= 1'b0;
            rvalid_ff  <= 1'b0;
            rdata_ff   <= 32'h0000_0000;
            rresp_ff   <= RESP_OKAY;
        end
        else
        begin
            arready_ff <= !nxt_rvalid;
            rvalid_ff  <= nxt_rvalid;
            if (ar_take)
            begin
                rdata_ff <= rd_word;
                rresp_ff <= is_mapped(rd_addr) ? RESP_OKAY : RESP_SLVERR;
            end
        end
    end

    // Request built from the field register, prefix and fixed zeros forced
    assign built_q = '{prefix: PHY_PREFIX, dest_node_number: req_ff[29:24], zero: 2'h0,
                       pkt_type: req_ff[21:18], page: req_ff[17:15], port: req_ff[14:11],
                       reg_sel: req_ff[10:8], rsvd: 8'h00};

    // Check of the loaded request before it may leave
    logic       tx_pair_ok, tx_is_phy, tx_type_ok, tx_good;
    logic [3:0] tx_tgt;

    phy_quadlet_check u_tx_check (
        .first_q  (access_q_t'(buf0_ff)),
        .second_q (buf1_ff),
        .pair_ok  (tx_pair_ok),
        .is_phy   (tx_is_phy),
        .type_ok  (tx_type_ok),
        .reg_addr (tx_tgt)
    );

    assign tx_good = tx_pair_ok && tx_is_phy && tx_type_ok;

    // Transmit sequencing, two quadlets per request
    always_comb
    begin
        nxt_state = state_ff;
        case (state_ff)
            TX_IDLE:  if (tx_pend_ff && tx_good) nxt_state = TX_FIRST;
            TX_FIRST: if (phy_tx_ready) nxt_state = TX_LAST;
            TX_LAST:  if (phy_tx_ready) nxt_state = TX_IDLE;
            default:  nxt_state = TX_IDLE;
        endcase
    end

    // Request buffer, field register and transmit outputs
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            req_ff      <= REQ_RESET;
            buf0_ff     <= 32'h0000_0000;
            buf1_ff     <= 32'h0000_0000;
            tx_pend_ff  <= 1'b0;
            state_ff    <= TX_IDLE;
            tx_valid_ff <= 1'b0;
            tx_last_ff  <= 1'b0;
            tx_data_ff  <= 32'h0000_0000;
            tgt_ff      <= 4'h0;
        end
        else
        begin
            if (wr_req)
                req_ff <= merge_strb(req_ff, w_data_ff, w_strb_ff);
            if (send_cmd)
            begin
                buf0_ff <= built_q;
                buf1_ff <= ~built_q;
            end
            else if (wr_acc)
                buf0_ff <= merge_strb(buf0_ff, w_data_ff, w_strb_ff);
            if (wr_last)
                buf1_ff <= merge_strb(buf1_ff, w_data_ff, w_strb_ff);
            tx_pend_ff  <= send_cmd || wr_last;
            state_ff    <= nxt_state;
            tx_valid_ff <= (nxt_state != TX_IDLE);
            tx_last_ff  <= (nxt_state == TX_LAST);
            tx_data_ff  <= (nxt_state == TX_LAST) ? buf1_ff : buf0_ff;
            if (tx_pend_ff && tx_good)
                tgt_ff <= tx_tgt;
        end
    end

    // Receive quadlet capture and length count
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            rx_cnt_ff  <= 14'h0000;
            rx_len_ff  <= 14'h0000;
            rx_q0_ff   <= 32'h0000_0000;
            rx_q1_ff   <= 32'h0000_0000;
            rx_eval_ff <= 1'b0;
            meta_ff    <= '0;
        end
        else
        begin
            rx_eval_ff <= phy_rx_valid && phy_rx_last;
            if (phy_rx_valid)
            begin
                if (rx_cnt_ff == 14'h0000)
                    rx_q0_ff <= phy_rx_data;
                if (rx_cnt_ff == 14'h0001)
                    rx_q1_ff <= phy_rx_data;
                if (phy_rx_last)
                begin
                    rx_cnt_ff <= 14'h0000;
                    rx_len_ff <= rx_cnt_ff + 14'h0001;
                    meta_ff   <= phy_rx_meta;
                end
                else if (rx_cnt_ff != 14'h3FFF)
                    rx_cnt_ff <= rx_cnt_ff + 14'h0001;
            end
        end
    end

    // Reply check and control token assembly
    logic       rx_pair_ok, rx_is_phy, rx_type_ok, rx_good;
    logic       clr_reply, clr_err, nxt_reply, nxt_rxerr, nxt_reject;

    phy_quadlet_check u_rx_check (
        .first_q  (access_q_t'(rx_q0_ff)),
        .second_q (rx_q1_ff),
        .pair_ok  (rx_pair_ok),
        .is_phy   (rx_is_phy),
        .type_ok  (rx_type_ok),
        .reg_addr ()
    );

    assign rx_good   = rx_eval_ff && (rx_len_ff == REPLY_QUADLETS) && rx_pair_ok &&
                       rx_is_phy && rx_type_ok && !meta_ff.self_id;
    assign nxt_token = '{rsvd_hi: 2'h0, quadlet_count: rx_len_ff,
                         self_id: meta_ff.self_id,
                         phy_pkt: rx_is_phy && !meta_ff.self_id,
                         rsvd_mid: 1'b0,
                         handshake_response_code: meta_ff.handshake_response_code,
                         pad: meta_ff.pad,
                         speed: meta_ff.speed,
                         rsvd_lo: 4'h0};
    assign clr_reply  = wr_ctrl && wr_merged[CTRL_CLR_REPLY_BIT];
    assign clr_err    = wr_ctrl && wr_merged[CTRL_CLR_ERR_BIT];
    assign nxt_reply  = rx_good || (reply_ff && !clr_reply);
    assign nxt_rxerr  = (rx_eval_ff && !rx_good) || (rxerr_ff && !clr_err);
    assign nxt_reject = (tx_pend_ff && !tx_good) || (reject_ff && !clr_err);

    // Stored reply, token and sticky flags, a set beats a clear
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            token_ff  <= '0;
            reply0_ff <= 32'h0000_0000;
            reply1_ff <= 32'h0000_0000;
            reply_ff  <= 1'b0;
            rxerr_ff  <= 1'b0;
            reject_ff <= 1'b0;
        end
        else
        begin
            if (rx_eval_ff)
                token_ff <= nxt_token;
            if (rx_good)
            begin
                reply0_ff <= rx_q0_ff;
                reply1_ff <= rx_q1_ff;
            end
            reply_ff  <= nxt_reply;
            rxerr_ff  <= nxt_rxerr;
            reject_ff <= nxt_reject;
        end
    end

    // Port drive, all from flip-flops
    assign awready      = awready_ff;
    assign wready       = wready_ff;
    assign bvalid       = bvalid_ff;
    assign bresp        = bresp_ff;
    assign arready      = arready_ff;
    assign rvalid       = rvalid_ff;
    assign rdata        = rdata_ff;
    assign rresp        = rresp_ff;
    assign phy_tx_valid = tx_valid_ff;
    assign phy_tx_last  = tx_last_ff;
    assign phy_tx_data  = tx_data_ff;

    // Checks on the framer's own behaviour
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    sequence s_first_taken;
        phy_tx_valid && !phy_tx_last && phy_tx_ready;
    endsequence
    sequence s_last_offered;
        phy_tx_valid && phy_tx_last && (phy_tx_data == ~buf0_ff);
    endsequence

    a_tx_two_quadlets: assert property (s_first_taken |=> s_last_offered)
        else $error("last quadlet not offered after first");
    a_tx_prefix_zero: assert property (phy_tx_valid && !phy_tx_last |->
        phy_tx_data[31:30] == 2'b00) else $error("request prefix not zero");
    a_tx_type_legal: assert property (phy_tx_valid && !phy_tx_last |->
        (phy_tx_data[21:18] == 4'h1) || (phy_tx_data[21:18] == 4'h5))
        else $error("illegal request type sent");
    a_base_reg_addr: assert property (phy_tx_valid && phy_tx_data[21:18] == 4'h1
        && !phy_tx_last |-> tgt_ff == {1'b0, phy_tx_data[10:8]})
        else $error("base register address wrong");
    a_paged_reg_addr: assert property (phy_tx_valid && phy_tx_data[21:18] == 4'h5
        && !phy_tx_last |-> tgt_ff == 4'h8 + {1'b0, phy_tx_data[10:8]})
        else $error("paged register address wrong");
    a_reply_stored: assert property (rx_good |=> reply_ff &&
        reply0_ff == $past(rx_q0_ff) && reply1_ff == ~reply0_ff)
        else $error("good reply not stored");
    a_token_size: assert property (rx_eval_ff |=>
        token_ff.quadlet_count == $past(rx_len_ff)) else $error("token size wrong");
    a_token_flags: assert property (rx_eval_ff |=> token_ff.self_id == $past(meta_ff.self_id)
        && token_ff.phy_pkt == ($past(rx_q0_ff[31:30]) == 2'b00 && !token_ff.self_id))
        else $error("token flags wrong");
    a_token_fields: assert property (rx_eval_ff |=> token_ff[12:4] ==
        {$past(meta_ff.handshake_response_code), $past(meta_ff.pad), $past(meta_ff.speed)})
        else $error("token code, pad or speed wrong");
    a_bad_pair_dropped: assert property (rx_eval_ff && !rx_pair_ok && !reply_ff |=>
        !reply_ff && rxerr_ff) else $error("broken reply not discarded");

endmodule

// File: include/rpra_pkg.sv
// Constants, layouts and types for the remote PHY register access framer
package rpra_pkg;

    // Register byte offsets
    localparam logic [7:0] OFF_CTRL     = 8'h00;
    localparam logic [7:0] OFF_REQ      = 8'h04;
    localparam logic [7:0] OFF_BUF_ACC  = 8'h08;
    localparam logic [7:0] OFF_BUF_LAST = 8'h0C;
    localparam logic [7:0] OFF_STATUS   = 8'h10;
    localparam logic [7:0] OFF_TOKEN    = 8'h14;
    localparam logic [7:0] OFF_REPLY0   = 8'h18;
    localparam logic [7:0] OFF_REPLY1   = 8'h1C;

    // Control bit positions
    localparam int unsigned CTRL_SEND_BIT      = 0;
    localparam int unsigned CTRL_CLR_REPLY_BIT = 1;
    localparam int unsigned CTRL_CLR_ERR_BIT   = 2;

    // Status bit positions
    localparam int unsigned ST_BUSY_BIT   = 0;
    localparam int unsigned ST_REPLY_BIT  = 1;
    localparam int unsigned ST_RXERR_BIT  = 2;
    localparam int unsigned ST_REJECT_BIT = 3;
    localparam int unsigned ST_TGT_LO     = 8;

    // Packet codes and reset values
    localparam logic [1:0]  PHY_PREFIX      = 2'h0;
    localparam logic [3:0]  TYPE_BASE_READ  = 4'h1;
    localparam logic [3:0]  TYPE_PAGED_READ = 4'h5;
    localparam logic [3:0]  PAGED_REG_BASE  = 4'h8;
    localparam logic [31:0] REQ_RESET       = 32'h0004_0000;
    localparam logic [13:0] REPLY_QUADLETS  = 14'h0002;
    localparam logic [1:0]  SPD_100         = 2'h0;
    localparam logic [1:0]  SPD_200         = 2'h1;
    localparam logic [1:0]  SPD_400         = 2'h2;
    localparam logic [1:0]  RESP_OKAY       = 2'h0;
    localparam logic [1:0]  RESP_SLVERR     = 2'h2;

    // First quadlet of a remote access request or reply
    typedef struct packed {
        logic [1:0] prefix;
        logic [5:0] dest_node_number;
        logic [1:0] zero;
        logic [3:0] pkt_type;
        logic [2:0] page;
        logic [3:0] port;
        logic [2:0] reg_sel;
        logic [7:0] rsvd;
    } access_q_t;

    // Packet control token stored with a received packet
    typedef struct packed {
        logic [1:0]  rsvd_hi;
        logic [13:0] quadlet_count;
        logic        self_id;
        logic        phy_pkt;
        logic        rsvd_mid;
        logic [4:0]  handshake_response_code;
        logic [1:0]  pad;
        logic [1:0]  speed;
        logic [3:0]  rsvd_lo;
    } token_t;

    // Per-packet information from the serial bus receiver
    typedef struct packed {
        logic [4:0] handshake_response_code;
        logic [1:0] pad;
        logic [1:0] speed;
        logic       self_id;
    } rx_meta_t;

    typedef enum logic [1:0] {
        TX_IDLE  = 2'b00,
        TX_FIRST = 2'b01,
        TX_LAST  = 2'b10
    } tx_state_t;

    // Remote PHY register address addressed by a request quadlet
    function automatic logic [3:0] target_addr(input access_q_t q);
        target_addr = (q.pkt_type == TYPE_PAGED_READ) ? (PAGED_REG_BASE + {1'b0, q.reg_sel})
                                                       : {1'b0, q.reg_sel};
    endfunction

endpackage

// File: verilog/phy_quadlet_check.sv
// Validity check of a two-quadlet remote access packet
`timescale 1ns/100ps
module phy_quadlet_check
    import rpra_pkg::*;
(
    // Packet quadlets
    input  wire access_q_t   first_q,
    input  wire logic [31:0] second_q,
    // Check results
    output logic             pair_ok,
    output logic             is_phy,
    output logic             type_ok,
    output logic [3:0]       reg_addr
);

    // Inverse pairing, prefix and type decode
    assign pair_ok  = (second_q == ~first_q);
    assign is_phy   = (first_q.prefix == PHY_PREFIX);
    assign type_ok  = (first_q.pkt_type == TYPE_BASE_READ) ||
                      (first_q.pkt_type == TYPE_PAGED_READ);
    assign reg_addr = target_addr(first_q);

endmodule

// File: verification/phy_far_end.sv
// Far-end physical layer model that echoes each remote access request as a reply
`timescale 1ns/100ps
module phy_far_end
(
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        rst,
    // Request quadlets from the framer
    input  wire logic        phy_tx_valid,
    input  wire logic [31:0] phy_tx_data,
    input  wire logic        phy_tx_last,
    output logic             phy_tx_ready,
    // Reply quadlets toward the framer
    output logic             phy_rx_valid,
    output logic [31:0]      phy_rx_data,
    output logic             phy_rx_last,
    // Fault injection: flips one bit of the second reply quadlet
    input  wire logic        corrupt
);
    logic [31:0] first_ff;
    logic [2:0]  wait_ff;
    // Stalls at random, replies a few cycles after the last request quadlet
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            {phy_tx_ready, phy_rx_valid, phy_rx_last, wait_ff} <= '0;
            {phy_rx_data, first_ff} <= '0;
        end
        else
        begin
            phy_tx_ready <= 1'($urandom);
            if (phy_tx_valid && phy_tx_ready && !phy_tx_last) first_ff <= phy_tx_data;
            wait_ff <= (phy_tx_valid && phy_tx_ready && phy_tx_last) ? 3'h5
                     : (wait_ff != 3'h0) ? wait_ff - 3'h1 : 3'h0;
            phy_rx_valid <= (wait_ff == 3'h2) || (wait_ff == 3'h1);
            phy_rx_last  <= (wait_ff == 3'h1);
            // Idle line toggles instead of holding the last quadlet
            phy_rx_data  <= (wait_ff == 3'h2) ? first_ff
                          : (wait_ff == 3'h1) ? (~first_ff ^ {31'h0, corrupt})
                          : ~phy_rx_data;
        end
    end
endmodule

// File: verification/remote_phy_register_access_tb.sv
// Self-checking bench for the remote PHY register access framer
`timescale 1ns/100ps
module remote_phy_register_access_tb;
    import rpra_pkg::*;
    logic        clock, rst, awvalid, wvalid, bready, arvalid, rready, awready, wready;
    logic        bvalid, arready, rvalid, phy_tx_valid, phy_tx_last, phy_tx_ready;
    logic        phy_rx_valid, phy_rx_last, corrupt;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata, phy_tx_data, phy_rx_data;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp;
    rx_meta_t    phy_rx_meta;
    int          n_errors, n_tests;
    logic [33:0] rq[$], tq[$];
    remote_phy_register_access dut (.clock, .rst, .awaddr, .awvalid, .awready, .wdata, .wstrb,
        .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
        .rvalid, .rready, .phy_tx_valid, .phy_tx_data, .phy_tx_last, .phy_tx_ready,
        .phy_rx_valid, .phy_rx_data, .phy_rx_last, .phy_rx_meta);
    phy_far_end far (.clock, .rst, .phy_tx_valid, .phy_tx_data, .phy_tx_last, .phy_tx_ready,
        .phy_rx_valid, .phy_rx_data, .phy_rx_last, .corrupt);
    // Clock source
    initial
    begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end
    task automatic chk(input string s, input logic [33:0] e, input logic [33:0] g);
        n_tests++;
        if (g !== e)
        begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", s, e, g);
        end
    endtask
    task automatic finish_test;
        if (n_errors == 0 && n_tests > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge clock);
        {awaddr, wdata, awvalid, wvalid, bready} <= {a, d, 3'h7};
        for (k = 0; k < 60; k++)
        begin
            @(posedge clock);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        bready <= 1'b0;
        if (k == 60) n_errors++;
        if (k == 60) finish_test();
        chk("bresp", {32'h0, RESP_OKAY}, {32'h0, bresp});
    endtask
    task automatic rd(input logic [7:0] a, input logic [33:0] e);
        int k;
        @(posedge clock);
        {araddr, arvalid, rready} <= {a, 2'h3};
        rq.push_back(e);
        for (k = 0; k < 60; k++)
        begin
            @(posedge clock);
            if (arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        rready <= 1'b0;
        if (k == 60) n_errors++;
        if (k == 60) finish_test();
    endtask
    task automatic wait_reply;
        int k;
        for (k = 0; k < 80; k++)
        begin
            @(posedge clock);
            if (phy_rx_valid && phy_rx_last) break;
        end
        if (k == 80) n_errors++;
        if (k == 80) finish_test();
        repeat (3) @(posedge clock);
    endtask
    // Compares each read answer and each sent quadlet with the oldest note
    always @(posedge clock)
    begin
        if (rvalid && rready) chk("rdata", rq.pop_front(), {rresp, rdata});
        if (phy_tx_valid && phy_tx_ready) chk("tx", tq.pop_front(), {1'b0, phy_tx_last, phy_tx_data});
    end
    // Main sequence
    initial
    begin
        logic [31:0] q;
        logic [3:0]  t;
        logic        sid;
        logic        drop;
        logic [3:0]  tg;
        {awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata, corrupt} = '0;
        {wstrb, rst, phy_rx_meta, n_errors, n_tests} = {4'hF, 1'b1, 10'h0, 64'h0};
        void'($urandom(57254));
        repeat (12) @(posedge clock);
        rst <= 1'b0;
        rd(OFF_REQ, {RESP_OKAY, REQ_RESET});
        rd(OFF_CTRL, {RESP_OKAY, 32'h0});
        rd(8'h20, {RESP_SLVERR, 32'h0});
        rd(8'h06, {RESP_SLVERR, 32'h0});
        for (int i = 0; i < 5; i++)
        begin
            sid = (i == 3);
            drop = sid || (i == 4);
            corrupt <= (i == 4);
            t = i[0] ? TYPE_PAGED_READ : TYPE_BASE_READ;
            q = {PHY_PREFIX, 6'($urandom), 2'h0, t, 7'($urandom), 3'($urandom), 8'h0};
            phy_rx_meta <= {7'($urandom), 2'(i % 3), sid};
            wr(OFF_CTRL, 32'h6);
            wr(OFF_REQ, q);
            tq.push_back({2'h0, q});
            tq.push_back({2'h1, ~q});
            wr(OFF_CTRL, 32'h1);
            wait_reply();
            tg = (i[0] ? PAGED_REG_BASE : 4'h0) + {1'b0, q[10:8]};
            rd(OFF_STATUS, {RESP_OKAY, 20'h0, tg, 5'h0, drop, ~drop, 1'b0});
            rd(OFF_TOKEN, {RESP_OKAY, 2'h0, REPLY_QUADLETS, sid, ~sid, 1'b0, phy_rx_meta[9:1], 4'h0});
            if (!drop) rd(OFF_REPLY0, {RESP_OKAY, q});
            if (!drop) rd(OFF_REPLY1, {RESP_OKAY, ~q});
        end
        q = {PHY_PREFIX, 6'h3F, 2'h0, TYPE_PAGED_READ, 3'h7, 4'hF, 3'h7, 8'hE0};
        tq.push_back({2'h0, q});
        tq.push_back({2'h1, ~q});
        wr(OFF_BUF_ACC, q);
        wr(OFF_BUF_LAST, ~q);
        wait_reply();
        wr(OFF_CTRL, 32'h6);
        wr(OFF_BUF_ACC, q);
        wr(OFF_BUF_LAST, q);
        repeat (4) @(posedge clock);
        rd(OFF_STATUS, {RESP_OKAY, 20'h0, 4'hF, 8'h08});
        finish_test();
    end
endmodule
